// ==== verilog/dbrh_pkg.sv ====
// Package for the diagnostic buffer read handler: command layout, modes, sense codes, sizes.
// Assumes one 200 MHz clock domain and byte-wide command and data streams.
package dbrh_pkg;

  // Command block layout.
  localparam logic [7:0] OPCODE_READ_BUF = 8'h3c;
  localparam int CDB_LEN = 10;
  localparam int CDB_MODE_BYTE = 1;
  localparam int CDB_SEL_BYTE = 2;
  localparam int CDB_OFS_BYTE = 3;
  localparam int CDB_ALLOC_BYTE = 6;

  // Mode encodings.
  localparam logic [2:0] MODE_HDR_DATA = 3'h0;
  localparam logic [2:0] MODE_DATA = 3'h2;
  localparam logic [2:0] MODE_DESC = 3'h3;

  // Buffer geometry and fixed reply bytes.
  localparam logic [23:0] BUF_CAPACITY = 24'h03fc00;
  localparam logic [7:0] OFS_BOUNDARY = 8'hff;
  localparam logic [23:0] HDR_LEN = 24'h000004;
  localparam int BUF_ADDR_W = 18;

  // Status and sense values.
  localparam logic [7:0] STATUS_GOOD = 8'h00;
  localparam logic [7:0] STATUS_CHECK = 8'h02;
  localparam logic [3:0] SENSE_NONE = 4'h0;
  localparam logic [3:0] SENSE_ILLEGAL_REQ = 4'h5;
  localparam logic [7:0] ASC_NONE = 8'h00;
  localparam logic [7:0] ASC_INVALID_CDB = 8'h24;

  // Handler states, Gray coded along idle, command, check, send, done.
  typedef enum logic [2:0] {
    DBRH_IDLE = 3'b000,
    DBRH_CMD = 3'b001,
    DBRH_CHECK = 3'b011,
    DBRH_SEND = 3'b010,
    DBRH_DONE = 3'b110
  } dbrh_state_t;

  // Ending of one command.
  typedef struct packed {
    logic [7:0] status;
    logic [3:0] sense_key;
    logic [7:0] asc;
  } dbrh_result_t;

  // One outgoing DATA IN byte.
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } dbrh_byte_t;

endpackage

// ==== verilog/dbrh_buf_ram.sv ====
// Byte-wide diagnostic data buffer with one synchronous read port.
// Assumes writes come from the companion buffer write path outside this handler.
`timescale 1ns/10ps
`default_nettype none
module dbrh_buf_ram (
  // Clock.
  input wire logic clk_i,
  // Write port.
  input wire logic wr_en_i,
  input wire logic [dbrh_pkg::BUF_ADDR_W-1:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  // Read port, one cycle latency.
  input wire logic [dbrh_pkg::BUF_ADDR_W-1:0] rd_addr_i,
  output logic [7:0] rd_data_o
);

  logic [7:0] mem [0:(1<<dbrh_pkg::BUF_ADDR_W)-1];

  // Stores written bytes and returns the addressed byte a cycle later.
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end

endmodule
`default_nettype wire

// ==== verilog/dbrh_handler.sv ====
// Read buffer diagnostic command handler: takes a command block, sends DATA IN, ends with status.
// Assumes the initiator side feeds command bytes one a cycle and accepts bytes with ready.
//
// Notes on behaviour
// - Command only reads internal buffer; nothing on the medium changes.
// - Mode 000 header and data, 010 raw data, 011 descriptor.
// - Unacceptable offset ends with check condition, illegal request, invalid field.
// - Offset plus length past capacity ends with the same check condition.
// - Mode 000 sends four header bytes then data; selector and offset ignored.
// - Mode 000 with zero allocation length sends nothing.
// - Mode 000 stops at allocation length or end of header and data.
// - Header is a reserved byte then three-byte available length, MSB first.
// - Available length always reads 261,120 bytes.
// - Data bytes after header are the lesser of allocation minus four and available.
// - Mode 010 sends raw data; nonzero selector gives check condition.
// - Mode 011 sends the descriptor; nonzero selector gives all zeros.
// - Mode 011 ignores offset and sends the lesser of allocation and four bytes.
// - Descriptor byte 0 is boundary code FFH, zero for nonzero selector.
// - Descriptor bytes 1 to 3 hold capacity MSB first, zero for nonzero selector.
`timescale 1ns/10ps
`default_nettype none
module dbrh_handler (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Command block bytes.
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_byte_i,
  // Buffer fill path from the write side.
  input wire logic buf_wr_en_i,
  input wire logic [dbrh_pkg::BUF_ADDR_W-1:0] buf_wr_addr_i,
  input wire logic [7:0] buf_wr_data_i,
  // DATA IN stream.
  input wire logic din_ready_i,
  output var dbrh_pkg::dbrh_byte_t din_o,
  output logic din_last_o,
  // Command ending.
  output logic done_o,
  output var dbrh_pkg::dbrh_result_t result_o,
  output logic busy_o
);

  // Whole handler state.
  typedef struct packed {
    dbrh_pkg::dbrh_state_t state;
    logic [3:0] idx;
    logic [2:0] mode;
    logic [7:0] sel;
    logic [23:0] ofs;
    logic [23:0] alloc;
    logic [23:0] total;
    logic [23:0] sent;
    logic [23:0] rd_ptr;
    logic fetched;
    logic bad_op;
    dbrh_pkg::dbrh_byte_t din;
    logic din_last;
    logic done;
    dbrh_pkg::dbrh_result_t result;
    logic busy;
  } dbrh_regs_t;

  dbrh_regs_t r;
  dbrh_regs_t next_r;
  logic [7:0] rd_data;
  logic [24:0] end_pos;
  logic [23:0] data_room;
  logic [7:0] out_byte;
  logic is_data;

  // The buffer is read only here; no medium path exists in this block.
  dbrh_buf_ram u_ram (
    .clk_i(clk_i),
    .wr_en_i(buf_wr_en_i),
    .wr_addr_i(buf_wr_addr_i),
    .wr_data_i(buf_wr_data_i),
    .rd_addr_i(r.rd_ptr[dbrh_pkg::BUF_ADDR_W-1:0]),
    .rd_data_o(rd_data)
  );

  // Offset plus length and header-mode data room.
  assign end_pos = {1'b0, r.ofs} + {1'b0, r.alloc};
  assign data_room = (r.alloc > dbrh_pkg::HDR_LEN) ? r.alloc - dbrh_pkg::HDR_LEN : 24'h000000;

  // Chooses the byte for the current position of the reply.
  always_comb begin
    out_byte = 8'h00;
    is_data = 1'b1;
    if (r.mode == dbrh_pkg::MODE_HDR_DATA && r.sent < dbrh_pkg::HDR_LEN) begin
      is_data = 1'b0;
      case (r.sent[1:0])
        2'h0: out_byte = 8'h00;
        2'h1: out_byte = dbrh_pkg::BUF_CAPACITY[23:16];
        2'h2: out_byte = dbrh_pkg::BUF_CAPACITY[15:8];
        default: out_byte = dbrh_pkg::BUF_CAPACITY[7:0];
      endcase
    end else if (r.mode == dbrh_pkg::MODE_DESC) begin
      is_data = 1'b0;
      case (r.sent[1:0])
        2'h0: out_byte = (r.sel == 8'h00) ? dbrh_pkg::OFS_BOUNDARY : 8'h00;
        2'h1: out_byte = (r.sel == 8'h00) ? dbrh_pkg::BUF_CAPACITY[23:16] : 8'h00;
        2'h2: out_byte = (r.sel == 8'h00) ? dbrh_pkg::BUF_CAPACITY[15:8] : 8'h00;
        default: out_byte = (r.sel == 8'h00) ? dbrh_pkg::BUF_CAPACITY[7:0] : 8'h00;
      endcase
    end else begin
      out_byte = rd_data;
    end
  end

  // Next-state logic for the whole handler.
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (r.din.valid && din_ready_i) begin
      next_r.din.valid = 1'b0;
      next_r.din_last = 1'b0;
    end
    case (r.state)
      dbrh_pkg::DBRH_IDLE: begin
        next_r.idx = 4'h0;
        next_r.bad_op = 1'b0;
        if (cmd_valid_i) begin
          next_r.state = dbrh_pkg::DBRH_CMD;
          next_r.idx = 4'h1;
          next_r.bad_op = (cmd_byte_i != dbrh_pkg::OPCODE_READ_BUF);
        end
      end
      dbrh_pkg::DBRH_CMD: begin
        if (cmd_valid_i) begin
          case (r.idx)
            4'(dbrh_pkg::CDB_MODE_BYTE): next_r.mode = cmd_byte_i[2:0];
            4'(dbrh_pkg::CDB_SEL_BYTE): next_r.sel = cmd_byte_i;
            4'(dbrh_pkg::CDB_OFS_BYTE): next_r.ofs[23:16] = cmd_byte_i;
            4'(dbrh_pkg::CDB_OFS_BYTE + 1): next_r.ofs[15:8] = cmd_byte_i;
            4'(dbrh_pkg::CDB_OFS_BYTE + 2): next_r.ofs[7:0] = cmd_byte_i;
            4'(dbrh_pkg::CDB_ALLOC_BYTE): next_r.alloc[23:16] = cmd_byte_i;
            4'(dbrh_pkg::CDB_ALLOC_BYTE + 1): next_r.alloc[15:8] = cmd_byte_i;
            4'(dbrh_pkg::CDB_ALLOC_BYTE + 2): next_r.alloc[7:0] = cmd_byte_i;
            default: next_r.idx = r.idx;
          endcase
          next_r.idx = r.idx + 4'h1;
          if (r.idx == 4'(dbrh_pkg::CDB_LEN - 1)) begin
            next_r.state = dbrh_pkg::DBRH_CHECK;
          end
        end
      end
      dbrh_pkg::DBRH_CHECK: begin
        next_r.sent = 24'h000000;
        next_r.fetched = 1'b0;
        next_r.result = '{dbrh_pkg::STATUS_CHECK, dbrh_pkg::SENSE_ILLEGAL_REQ,
                          dbrh_pkg::ASC_INVALID_CDB};
        next_r.state = dbrh_pkg::DBRH_DONE;
        case (r.mode)
          dbrh_pkg::MODE_HDR_DATA: begin
            // Selector and offset are reserved here and not looked at.
            next_r.rd_ptr = 24'h000000;
            next_r.total = (r.alloc < dbrh_pkg::HDR_LEN) ? r.alloc :
              dbrh_pkg::HDR_LEN + ((data_room < dbrh_pkg::BUF_CAPACITY) ?
              data_room : dbrh_pkg::BUF_CAPACITY);
          end
          dbrh_pkg::MODE_DATA: begin
            next_r.rd_ptr = r.ofs;
            next_r.total = r.alloc;
          end
          default: begin
            // Descriptor: offset is ignored.
            next_r.rd_ptr = 24'h000000;
            next_r.total = (r.alloc < dbrh_pkg::HDR_LEN) ? r.alloc : dbrh_pkg::HDR_LEN;
          end
        endcase
        if (r.bad_op || !(r.mode == dbrh_pkg::MODE_HDR_DATA || r.mode == dbrh_pkg::MODE_DATA ||
            r.mode == dbrh_pkg::MODE_DESC)) begin
          next_r.state = dbrh_pkg::DBRH_DONE;
        end else if (r.mode == dbrh_pkg::MODE_DATA && r.sel != 8'h00) begin
          next_r.state = dbrh_pkg::DBRH_DONE;
        end else if (r.mode == dbrh_pkg::MODE_DATA && r.ofs >= dbrh_pkg::BUF_CAPACITY) begin
          next_r.state = dbrh_pkg::DBRH_DONE;
        end else if (r.mode == dbrh_pkg::MODE_DATA &&
                     end_pos > {1'b0, dbrh_pkg::BUF_CAPACITY}) begin
          next_r.state = dbrh_pkg::DBRH_DONE;
        end else begin
          next_r.result = '{dbrh_pkg::STATUS_GOOD, dbrh_pkg::SENSE_NONE, dbrh_pkg::ASC_NONE};
          next_r.state = dbrh_pkg::DBRH_SEND;
        end
      end
      dbrh_pkg::DBRH_SEND: begin
        // Buffer reads take one cycle, so a byte is fetched before it is offered.
        if (r.sent == r.total) begin
          if (!r.din.valid || din_ready_i) begin
            next_r.state = dbrh_pkg::DBRH_DONE;
          end
        end else if (!r.din.valid || din_ready_i) begin
          if (is_data && !r.fetched) begin
            next_r.fetched = 1'b1;
          end else begin
            next_r.din.valid = 1'b1;
            next_r.din.data = out_byte;
            next_r.din_last = (r.sent + 24'h000001 == r.total);
            next_r.sent = r.sent + 24'h000001;
            next_r.fetched = 1'b0;
            if (is_data) begin
              next_r.rd_ptr = r.rd_ptr + 24'h000001;
            end
          end
        end
      end
      dbrh_pkg::DBRH_DONE: begin
        next_r.done = 1'b1;
        next_r.state = dbrh_pkg::DBRH_IDLE;
      end
      default: next_r.state = dbrh_pkg::DBRH_IDLE;
    endcase
    // Busy is kept in its own flop so the output has no decode after the register.
    next_r.busy = (next_r.state != dbrh_pkg::DBRH_IDLE);
  end

  // Registers the whole state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flip-flops.
  assign din_o = r.din;
  assign din_last_o = r.din_last;
  assign done_o = r.done;
  assign result_o = r.result;
  assign busy_o = r.busy;

endmodule
`default_nettype wire

// ==== bench/dbrh_handler_asserts.sv ====
// Checker for the buffer read handler, watching only its ports.
// Assumes one clock domain and a bind from the bench top file.
`timescale 1ns/10ps
`default_nettype none
module dbrh_handler_asserts (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched ports.
  input wire logic cmd_valid_i,
  input wire logic din_ready_i,
  input wire dbrh_pkg::dbrh_byte_t din_o,
  input wire logic din_last_o,
  input wire logic done_o,
  input wire dbrh_pkg::dbrh_result_t result_o,
  input wire logic busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // The last byte is handed over, then the command ends shortly after.
  sequence last_take_s;
    din_o.valid && din_last_o && din_ready_i;
  endsequence
  sequence ending_s;
    ##[1:4] done_o;
  endsequence
  end_after_last_a: assert property (last_take_s |-> ending_s)
    else $error("no ending after last byte");
  done_pulse_a: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  check_sense_a: assert property (done_o && result_o.status == dbrh_pkg::STATUS_CHECK
    |-> result_o.sense_key == dbrh_pkg::SENSE_ILLEGAL_REQ && result_o.asc == 8'h24)
    else $error("wrong sense on check condition");
  good_sense_a: assert property (done_o && result_o.status != 8'h02
    |-> result_o.status == 8'h00 && result_o.sense_key == 4'h0 && result_o.asc == 8'h00)
    else $error("wrong good ending");
  hold_byte_a: assert property (din_o.valid && !din_ready_i
    |=> $stable(din_o) && $stable(din_last_o))
    else $error("byte changed before acceptance");
  last_valid_a: assert property (din_last_o |-> din_o.valid)
    else $error("last flag without byte");
  quiet_idle_a: assert property (!busy_o |-> !din_o.valid)
    else $error("byte offered while idle");
  result_hold_a: assert property (!busy_o && !cmd_valid_i && !done_o |=> $stable(result_o))
    else $error("result changed while idle");
  no_data_done_a: assert property (done_o |-> !din_o.valid)
    else $error("byte offered at ending");
endmodule
`default_nettype wire

// ==== bench/dbrh_initiator.sv ====
// Initiator model: sends command blocks and takes DATA IN bytes.
// Assumes the handler samples its inputs on the rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module dbrh_initiator (
  // Clock.
  input wire logic clk_i,
  // Command and DATA IN side.
  output logic cmd_valid_o,
  output logic [7:0] cmd_byte_o,
  output logic din_ready_o,
  input wire dbrh_pkg::dbrh_byte_t din_i
);
  logic slow = 1'b0;
  logic [15:0] r = 16'h9151;
  logic [7:0] rx_q[$];
  // Idle levels at time zero.
  initial begin
    cmd_valid_o = 1'b0;
    cmd_byte_o = 8'h00;
    din_ready_o = 1'b1;
  end
  // Stalls come from a shift register when the slow mode is on.
  always @(negedge clk_i) begin
    r <= {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
    din_ready_o <= slow ? r[0] : 1'b1;
  end
  // A byte is taken at the edge where valid meets ready.
  always @(posedge clk_i) begin
    if (din_i.valid && din_ready_o) rx_q.push_back(din_i.data);
  end
  // Sends one command block, opcode first, then drops valid and inverts the byte lines.
  task automatic send(input logic [79:0] cdb);
    for (int i = 9; i >= 0; i--) begin
      @(negedge clk_i);
      cmd_valid_o = 1'b1;
      cmd_byte_o = cdb[i*8 +: 8];
    end
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    cmd_byte_o = ~cmd_byte_o;
  endtask
endmodule
`default_nettype wire

// ==== bench/dbrh_handler_tb_top.sv ====
// Self-checking bench for the buffer read handler with a queue model.
// Assumes the initiator model file and the checker file are compiled first.
`timescale 1ns/10ps
`default_nettype none
module dbrh_handler_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid_i, din_ready_i, din_last_o, done_o, busy_o, buf_wr_en_i = 1'b0;
  logic [7:0] cmd_byte_i;
  logic [7:0] buf_wr_data_i = 8'h00;
  logic [dbrh_pkg::BUF_ADDR_W-1:0] buf_wr_addr_i = '0;
  dbrh_pkg::dbrh_byte_t din_o;
  dbrh_pkg::dbrh_result_t result_o;
  int bad_count = 0;
  int checked = 0;
  int taken = 0;
  int last_pos = 0;
  logic [15:0] seed = 16'h9151;
  logic [7:0] mem [int];
  // Clock of 5 ns period.
  always #2.5 clk_i = ~clk_i;
  dbrh_handler dbrh_handler_inst (.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_byte_i(cmd_byte_i), .buf_wr_en_i(buf_wr_en_i), .buf_wr_addr_i(buf_wr_addr_i),
    .buf_wr_data_i(buf_wr_data_i), .din_ready_i(din_ready_i), .din_o(din_o),
    .din_last_o(din_last_o), .done_o(done_o), .result_o(result_o), .busy_o(busy_o));
  dbrh_initiator dbrh_initiator_inst (.clk_i(clk_i), .cmd_valid_o(cmd_valid_i),
    .cmd_byte_o(cmd_byte_i), .din_ready_o(din_ready_i), .din_i(din_o));
  // Counts bytes taken and notes at which count the last flag stood.
  always @(posedge clk_i) begin
    if (din_o.valid && din_ready_i) begin
      taken <= taken + 1;
      if (din_last_o) last_pos <= taken + 1;
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Runs one command and compares ending and bytes with the model.
  task automatic run(input logic [7:0] op, input logic [2:0] md, input logic [7:0] sel,
                     input logic [23:0] ofs, input logic [23:0] al);
    logic [7:0] exp_q[$];
    logic [31:0] av;
    logic bad;
    int n;
    av = 261120;
    bad = op != 8'h3c || !(md inside {3'h0, 3'h2, 3'h3}) || (md == 3'h2 &&
      (sel != 8'h00 || ofs >= av[23:0] || int'(ofs) + int'(al) > 261120));
    for (int i = 0; !bad && i < int'(al); i++) begin
      if (md == 3'h0) exp_q.push_back(i < 4 ? (i == 0 ? 8'h00 : av[8*(3-i) +: 8]) : mem[i-4]);
      if (md == 3'h2) exp_q.push_back(mem[int'(ofs) + i]);
      if (md == 3'h3 && i < 4) exp_q.push_back(sel != 8'h00 ? 8'h00 :
        (i == 0 ? 8'hff : av[8*(3-i) +: 8]));
    end
    dbrh_initiator_inst.rx_q = {};
    taken = 0;
    last_pos = 0;
    dbrh_initiator_inst.send({op, 5'h00, md, sel, ofs, al, 8'h00});
    n = 0;
    while (done_o !== 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    check(done_o, 1'b1);
    check({result_o}, bad ? 20'h02524 : 20'h0);
    check(dbrh_initiator_inst.rx_q.size(), exp_q.size());
    foreach (exp_q[i]) check(dbrh_initiator_inst.rx_q[i], exp_q[i]);
    check(last_pos, exp_q.size());
    n = 0;
    while (busy_o !== 1'b0 && n < 50) begin
      @(negedge clk_i);
      n++;
    end
    check(busy_o, 1'b0);
  endtask
  // Watchdog cutting a hang short.
  initial begin
    #300000;
    bad_count++;
    print_verdict;
  end
  // Main sequence: reset, buffer fill, commands.
  initial begin
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    for (int a = 0; a < 24; a++) begin
      @(negedge clk_i);
      seed = lfsr(seed);
      buf_wr_en_i = 1'b1;
      buf_wr_addr_i = 18'(a < 16 ? a : 261096 + a);
      buf_wr_data_i = seed[7:0];
      mem[int'(buf_wr_addr_i)] = seed[7:0];
    end
    @(negedge clk_i);
    buf_wr_en_i = 1'b0;
    for (int m = 0; m < 8; m++) run(8'h3c, 3'(m), 8'h00, 24'h0, 24'h4);
    run(8'h3c, 3'h3, 8'h01, 24'h0, 24'h9);
    run(8'h3c, 3'h3, 8'h00, 24'h5, 24'h2);
    run(8'h3c, 3'h0, 8'h07, 24'h9, 24'h0);
    seed = lfsr(seed);
    run(8'h3c, 3'h0, seed[15:8], {8'h00, seed}, 24'h3);
    dbrh_initiator_inst.slow = 1'b1;
    run(8'h3c, 3'h0, 8'h00, 24'h0, 24'h14);
    run(8'h3c, 3'h2, 8'h00, 24'h3, 24'ha);
    run(8'h3c, 3'h2, 8'h01, 24'h0, 24'h4);
    run(8'h3c, 3'h2, 8'h00, 24'h03fc00, 24'h1);
    run(8'h3c, 3'h2, 8'h00, 24'h03fbf8, 24'h9);
    run(8'h3c, 3'h2, 8'h00, 24'h03fbff, 24'h1);
    run(8'h12, 3'h3, 8'h00, 24'h0, 24'h4);
    print_verdict;
  end
endmodule
bind dbrh_handler dbrh_handler_asserts dbrh_handler_asserts_inst (.clk_i(clk_i),
  .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .din_ready_i(din_ready_i), .din_o(din_o),
  .din_last_o(din_last_o), .done_o(done_o), .result_o(result_o), .busy_o(busy_o));
`default_nettype wire
